// ---- hw/iop_pkg.sv ----
// Shared constants of the remappable I/O port block.
// Operation
// - Direction 1 makes input, 0 drives.
// - Reset sets every direction bit.
// - Latch reads back what was written.
// - Port reads pins; writes go to latch.
// - Open-drain bit covers every output source.
// - Analog select resets to all ones.
// - Direction and open-drain, not analog select, gate the digital driver.
// - Analog-selected pins read zero from port.
// - Change detection survives stopped clocks.
// - Per-pin enable lets changes request interrupts.
// - Status flags change since last port read.
// - Separate pull-up and pull-down enables.
// - Two-wire bus pins always open-drain.
// - Alias writes touch only bits written one.
// - Alias reads are undefined; read base.
// - Input select picks pin; some codes reserved.
// - Output selects reset to zero.
// - Aliases sit at base plus 4, 8, C.
package iop_pkg;
    localparam int          PINS        = 16;
    localparam int          IN_SELS     = 8;
    localparam logic [3:0]  PORT_REGS   = 4'hA;
    localparam logic [3:0]  IDX_DIR     = 4'h0;
    localparam logic [3:0]  IDX_PORT    = 4'h1;
    localparam logic [3:0]  IDX_LAT     = 4'h2;
    localparam logic [3:0]  IDX_ODC     = 4'h3;
    localparam logic [3:0]  IDX_ANSEL   = 4'h4;
    localparam logic [3:0]  IDX_CNEN    = 4'h5;
    localparam logic [3:0]  IDX_CNST    = 4'h6;
    localparam logic [3:0]  IDX_PU      = 4'h7;
    localparam logic [3:0]  IDX_PD      = 4'h8;
    localparam logic [3:0]  IDX_CNCON   = 4'h9;
    localparam logic [1:0]  OP_BASE     = 2'h0;
    localparam logic [1:0]  OP_CLR      = 2'h1;
    localparam logic [1:0]  OP_SET      = 2'h2;
    localparam logic [1:0]  OP_INV      = 2'h3;
    localparam logic [7:0]  PORT_PAGE   = 8'h00;
    localparam logic [15:0] IN_SEL_BASE = 16'hFA00;
    localparam int          CNCON_ON    = 15;
    localparam logic [15:0] RST_DIR     = 16'hFFFF;
    localparam logic [15:0] RST_ANSEL   = 16'hFFFF;
    localparam logic [3:0]  SEL_NONE    = 4'h0;
    localparam logic [15:0] OUT_SEL_PIN = 16'h03C2;
    localparam logic [15:0] IN_RSV      = 16'hC400;
    localparam logic [15:0] OUT_RSV_A   = 16'h1660;
    localparam logic [15:0] OUT_RSV_B   = 16'hE6A4;
    localparam logic [15:0] OUT_GRP_B   = 16'h0200;

    function automatic logic [15:0] out_sel_ofs(input int pin);
        case (pin)
            1:       return 16'hFC04;
            6:       return 16'hFC98;
            7:       return 16'hFC9C;
            8:       return 16'hFCA0;
            9:       return 16'hFCA4;
            default: return 16'h0000;
        endcase
    endfunction : out_sel_ofs
endpackage : iop_pkg

// ---- hw/iop_pad_if.sv ----
// Signals between the port core, the pad synchroniser and the pad driver.
`timescale 1ns/1ps
interface iop_pad_if;
    logic [iop_pkg::PINS-1:0] rawIn;
    logic [iop_pkg::PINS-1:0] level;
    logic [iop_pkg::PINS-1:0] changed;
    logic [iop_pkg::PINS-1:0] latch;
    logic [iop_pkg::PINS-1:0] tris;
    logic [iop_pkg::PINS-1:0] odc;
    logic [iop_pkg::PINS-1:0] forceOd;
    logic [iop_pkg::PINS-1:0] outAlt;
    logic [iop_pkg::PINS-1:0] altEn;
    logic [iop_pkg::PINS-1:0] drvOut;
    logic [iop_pkg::PINS-1:0] drvOe;
    modport sync (input rawIn, output level, output changed);
    modport drive (input latch, input tris, input odc, input forceOd,
                   input outAlt, input altEn, output drvOut, output drvOe);
endinterface : iop_pad_if

// ---- hw/iop_pin_sync.sv ----
// Two-stage pad synchroniser with per-pin change detection.
`timescale 1ns/1ps
module iop_pin_sync (
    input wire logic mclk,
    input wire logic srst,
    iop_pad_if.sync  pad
);
    typedef struct packed {
        logic [iop_pkg::PINS-1:0] meta;
        logic [iop_pkg::PINS-1:0] level;
        logic [iop_pkg::PINS-1:0] last;
    } iop_sync_s;

    iop_sync_s st;
    iop_sync_s next_st;

    always_comb begin
        next_st       = st;
        next_st.meta  = pad.rawIn;
        next_st.level = st.meta;
        next_st.last  = st.level;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // A level that moved while the clock stood still still differs from
    // the held sample at the first edge after restart, so it is not lost.
    assign pad.level   = st.level;
    assign pad.changed = st.level ^ st.last;
endmodule : iop_pin_sync

// ---- hw/iop_pad_drive.sv ----
// Pad driver: source choice and open-drain shaping per pin.
`timescale 1ns/1ps
module iop_pad_drive (
    iop_pad_if.drive pad
);
    logic [iop_pkg::PINS-1:0] src;
    logic [iop_pkg::PINS-1:0] od;

    assign src = (pad.altEn & pad.outAlt) | (~pad.altEn & pad.latch);
    assign od  = pad.odc | pad.forceOd;
    // Open-drain never drives high; it only pulls low or releases.
    assign pad.drvOut = src & ~od;
    assign pad.drvOe  = ~pad.tris & (~od | ~src);
endmodule : iop_pad_drive

// ---- hw/iop_port.sv ----
// Remappable I/O port: Wishbone register bank, pin remap, change notify.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module iop_port #(
    parameter logic [15:0] TWI_PINS = 16'h000C
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [15:0] padIn,
    output logic      [15:0] padOut,
    output logic      [15:0] padOe,
    output logic      [15:0] pullUpEn,
    output logic      [15:0] pullDownEn,
    output logic      [15:0] analogEn,
    input  wire logic [15:0] periphOut,
    output logic      [7:0]  periphIn,
    output logic             cnIrq
);
    localparam logic [3:0] DIR   = iop_pkg::IDX_DIR;
    localparam logic [3:0] PRT   = iop_pkg::IDX_PORT;
    localparam logic [3:0] LAT   = iop_pkg::IDX_LAT;
    localparam logic [3:0] ODC   = iop_pkg::IDX_ODC;
    localparam logic [3:0] ANS   = iop_pkg::IDX_ANSEL;
    localparam logic [3:0] CNEN  = iop_pkg::IDX_CNEN;
    localparam logic [3:0] CNST  = iop_pkg::IDX_CNST;
    localparam logic [3:0] CNCON = iop_pkg::IDX_CNCON;

    // The pin and select ports above are sized for these counts only.
    if (iop_pkg::PINS != 16 || iop_pkg::IN_SELS != 8) begin : g_bad_size
        $error("port needs sixteen pins and eight input selects");
    end

    ////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [iop_pkg::PORT_REGS-1:0][15:0] regs;
        logic [iop_pkg::IN_SELS-1:0][3:0]    inSel;
        logic [iop_pkg::PINS-1:0][3:0]       outSel;
        logic [15:0]                         drvOut;
        logic [15:0]                         drvOe;
        logic [7:0]                          periphIn;
        logic                                ack;
        logic [31:0]                         rdat;
        logic                                irq;
    } iop_port_s;

    iop_port_s   st;
    iop_port_s   next_st;
    iop_pad_if   pad ();

    logic        req;
    logic        wr;
    logic        rd;
    logic        isPort;
    logic        inHit;
    logic        portRd;
    logic        cnOn;
    logic [3:0]  idx;
    logic [3:0]  tgt;
    logic [1:0]  op;
    logic [2:0]  inIdx;
    logic [15:0] wmask;
    logic [15:0] wbits;
    logic [15:0] digIn;
    logic [15:0] outHit;
    logic [15:0] altEn;
    logic [15:0] outAlt;
    logic [7:0]  inVal;
    logic [15:0] dirQ;
    logic [15:0] latQ;
    logic [15:0] odcEff;
    logic [15:0] cnstQ;
    logic [15:0] cnenQ;

    ////////////////////////////////////////////////////////////////////////
    // Pad synchroniser and pad driver.

    iop_pin_sync u_sync (
        .mclk (mclk),
        .srst (srst),
        .pad  (pad)
    );

    iop_pad_drive u_drive (
        .pad (pad)
    );

    assign pad.rawIn   = padIn;
    assign pad.latch   = latQ;
    assign pad.tris    = dirQ;
    assign pad.odc     = st.regs[ODC];
    assign pad.forceOd = TWI_PINS;
    assign pad.outAlt  = outAlt;
    assign pad.altEn   = altEn;

    // The analog select turns the digital input path off, so peripherals
    // and the port both see zero on an analog pin.
    assign digIn = pad.level & ~st.regs[ANS];

    ////////////////////////////////////////////////////////////////////////
    // Remap selection per output pin and per peripheral input.

    for (genvar i = 0; i < iop_pkg::PINS; i++) begin : g_out
        localparam logic [15:0] RSV = iop_pkg::OUT_GRP_B[i] ?
                                      iop_pkg::OUT_RSV_B : iop_pkg::OUT_RSV_A;
        assign outHit[i] = iop_pkg::OUT_SEL_PIN[i] &&
                           wb_adr_i == iop_pkg::out_sel_ofs(i);
        // Code zero and reserved codes leave the pin on its latch.
        assign altEn[i]  = iop_pkg::OUT_SEL_PIN[i] &&
                           st.outSel[i] != iop_pkg::SEL_NONE &&
                           !RSV[st.outSel[i]];
        assign outAlt[i] = periphOut[st.outSel[i]];
    end

    for (genvar k = 0; k < iop_pkg::IN_SELS; k++) begin : g_in
        assign inVal[k] = !iop_pkg::IN_RSV[st.inSel[k]] &&
                          digIn[st.inSel[k]];
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        next_st      = st;
        next_st.ack  = 1'b0;
        next_st.rdat = 32'h0000_0000;
        req    = wb_cyc_i && wb_stb_i && !st.ack;
        wr     = req && wb_we_i;
        rd     = req && !wb_we_i;
        idx    = wb_adr_i[7:4];
        op     = wb_adr_i[3:2];
        isPort = wb_adr_i[15:8] == iop_pkg::PORT_PAGE &&
                 wb_adr_i[1:0] == 2'h0 && idx < iop_pkg::PORT_REGS;
        inHit  = wb_adr_i[15:5] == iop_pkg::IN_SEL_BASE[15:5] &&
                 wb_adr_i[1:0] == 2'h0;
        inIdx  = wb_adr_i[4:2];
        tgt    = (idx == PRT) ? LAT : idx;
        wmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        wbits  = wb_dat_i[15:0] & wmask;
        portRd = rd && isPort && idx == PRT && op == iop_pkg::OP_BASE;
        cnOn   = st.regs[CNCON][iop_pkg::CNCON_ON];

        // Register writes; the status register takes no software write.
        if (wr && isPort && tgt != CNST) begin
            unique case (op)
                iop_pkg::OP_BASE: begin
                    next_st.regs[tgt] = (st.regs[tgt] & ~wmask) | wbits;
                end
                iop_pkg::OP_CLR: begin
                    next_st.regs[tgt] = st.regs[tgt] & ~wbits;
                end
                iop_pkg::OP_SET: begin
                    next_st.regs[tgt] = st.regs[tgt] | wbits;
                end
                iop_pkg::OP_INV: begin
                    next_st.regs[tgt] = st.regs[tgt] ^ wbits;
                end
            endcase
        end
        if (wr && inHit && wb_sel_i[0]) begin
            next_st.inSel[inIdx] = wb_dat_i[3:0];
        end
        for (int i = 0; i < iop_pkg::PINS; i++) begin
            if (wr && outHit[i] && wb_sel_i[0]) begin
                next_st.outSel[i] = wb_dat_i[3:0];
            end
        end

        // Reads; aliases and unmapped addresses answer with zero.
        if (rd && isPort && op == iop_pkg::OP_BASE) begin
            next_st.rdat[15:0] = st.regs[idx];
        end else if (rd && inHit) begin
            next_st.rdat[3:0] = st.inSel[inIdx];
        end
        for (int i = 0; i < iop_pkg::PINS; i++) begin
            if (rd && outHit[i]) begin
                next_st.rdat[3:0] = st.outSel[i];
            end
        end
        next_st.ack = req;

        // The port slot holds the qualified pin levels for readback.
        next_st.regs[PRT] = digIn;

        // A change in the same cycle as a port read survives the clear.
        next_st.regs[CNST] = (portRd ? 16'h0000 : st.regs[CNST]) |
                             (cnOn ? pad.changed : 16'h0000);
        next_st.irq = cnOn && |(st.regs[CNST] & st.regs[CNEN]);

        next_st.drvOut   = pad.drvOut;
        next_st.drvOe    = pad.drvOe;
        next_st.periphIn = inVal;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st                <= '0;
            st.regs[DIR]      <= iop_pkg::RST_DIR;
            st.regs[ANS]      <= iop_pkg::RST_ANSEL;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign wb_dat_o   = st.rdat;
    assign wb_ack_o   = st.ack;
    assign padOut     = st.drvOut;
    assign padOe      = st.drvOe;
    assign pullUpEn   = st.regs[iop_pkg::IDX_PU];
    assign pullDownEn = st.regs[iop_pkg::IDX_PD];
    assign analogEn   = st.regs[ANS];
    assign periphIn   = st.periphIn;
    assign cnIrq      = st.irq;

    assign dirQ   = st.regs[DIR];
    assign latQ   = st.regs[LAT];
    assign odcEff = st.regs[ODC] | TWI_PINS;
    assign cnstQ  = st.regs[CNST];
    assign cnenQ  = st.regs[CNEN];

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_reset_values;
        disable iff (1'b0)
        srst |=> dirQ == 16'hFFFF && analogEn == 16'hFFFF &&
                 st.outSel == '0;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset values of direction, analog or remap wrong");

    property p_input_no_drive;
        1'b1 |=> (padOe & $past(dirQ)) == 16'h0000;
    endproperty
    a_input_no_drive: assert property (p_input_no_drive)
        else $error("a pin set as input is driven");

    property p_output_drives;
        !dirQ[0] && !odcEff[0] |=> padOe[0];
    endproperty
    a_output_drives: assert property (p_output_drives)
        else $error("push-pull output pin 0 not driven");

    property p_latch_readback;
        rd && isPort && idx == LAT && op == iop_pkg::OP_BASE
            |=> wb_ack_o && wb_dat_o == {16'h0000, $past(latQ)};
    endproperty
    a_latch_readback: assert property (p_latch_readback)
        else $error("latch read did not return latch contents");

    property p_port_write_latch;
        wr && isPort && idx == PRT && op == iop_pkg::OP_BASE &&
        wb_sel_i == 4'hF |=> latQ == $past(wb_dat_i[15:0]);
    endproperty
    a_port_write_latch: assert property (p_port_write_latch)
        else $error("port write did not land in latch");

    property p_analog_reads_zero;
        1'b1 |=> (st.regs[PRT] & $past(analogEn)) == 16'h0000;
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero)
        else $error("analog pin reads nonzero from port");

    property p_open_drain;
        1'b1 |=> (padOut & $past(odcEff)) == 16'h0000;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin driven high");

    property p_set_alias;
        wr && isPort && idx == LAT && op == iop_pkg::OP_SET &&
        wb_sel_i == 4'hF
            |=> latQ == ($past(latQ) | $past(wb_dat_i[15:0]));
    endproperty
    a_set_alias: assert property (p_set_alias)
        else $error("set alias changed bits written as zero");

    property p_clr_alias;
        wr && isPort && idx == DIR && op == iop_pkg::OP_CLR &&
        wb_sel_i == 4'hF
            |=> dirQ == ($past(dirQ) & ~$past(wb_dat_i[15:0]));
    endproperty
    a_clr_alias: assert property (p_clr_alias)
        else $error("clear alias at base plus four misbehaved");

    property p_alias_read;
        rd && isPort && op != iop_pkg::OP_BASE
            |=> wb_ack_o && wb_dat_o == 32'h0000_0000;
    endproperty
    a_alias_read: assert property (p_alias_read)
        else $error("alias read returned nonzero data");

    property p_change_sticky;
        cnOn && pad.changed != 16'h0000
            |=> (cnstQ & $past(pad.changed)) == $past(pad.changed);
    endproperty
    a_change_sticky: assert property (p_change_sticky)
        else $error("detected change not recorded in status");

    property p_irq_level;
        cnOn && (cnstQ & cnenQ) != 16'h0000 |=> cnIrq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("change request missing while status and enable set");

    property p_reserved_input;
        st.inSel[0] == 4'hA |=> !periphIn[0];
    endproperty
    a_reserved_input: assert property (p_reserved_input)
        else $error("reserved input code routed a pin");

    property p_unconnected_out;
        st.outSel[1] == iop_pkg::SEL_NONE && !odcEff[1]
            |=> padOut[1] == $past(latQ[1]);
    endproperty
    a_unconnected_out: assert property (p_unconnected_out)
        else $error("unconnected remap pin does not follow latch");

    property p_irq_gated;
        !cnOn || (cnstQ & cnenQ) == 16'h0000 |=> !cnIrq;
    endproperty
    a_irq_gated: assert property (p_irq_gated)
        else $error("change request raised without enabled status");

    property p_status_clear;
        portRd && !cnOn |=> cnstQ == 16'h0000;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("port read left change status set");
endmodule : iop_port

// ---- sim/iop_pin_model.sv ----
// Behavioural model of the pads and the world outside the port.
`timescale 1ns/1ps
module iop_pin_model (
    input  wire logic        mclk,
    input  wire logic [15:0] padOut,
    input  wire logic [15:0] padOe,
    input  wire logic [15:0] pullUpEn,
    input  wire logic [15:0] pullDownEn,
    input  wire logic [15:0] extVal,
    input  wire logic [15:0] extEn,
    output logic      [15:0] padIn
);
    logic flip = 1'b0;

    // A pin nobody drives wanders, so a stale level never passes a check.
    always @(posedge mclk) begin
        flip <= ~flip;
    end

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (padOe[i]) begin
                padIn[i] = padOut[i];
            end else if (extEn[i]) begin
                padIn[i] = extVal[i];
            end else if (pullUpEn[i]) begin
                padIn[i] = 1'b1;
            end else if (pullDownEn[i]) begin
                padIn[i] = 1'b0;
            end else begin
                padIn[i] = flip ^ i[0];
            end
        end
    end
endmodule : iop_pin_model

// ---- sim/testbench.sv ----
// Self-checking testbench of the remappable I/O port.
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] TWI = 16'h000C;
    logic        mclk = 0, srst = 1, cyc = 0, stb = 0, we = 0;
    logic [15:0] adr = 0, periphOut = 0, extVal = 0, extEn = 16'hFFFF;
    logic [3:0]  sel = 0;
    logic [31:0] wdat = 0, rdat, datO;
    logic        ack, cnIrq;
    logic [15:0] padIn, padOut, padOe, pullUp, pullDown, analog;
    logic [7:0]  periphIn;
    int          failures = 0, n_tests = 0, cycles = 0, seed = 39;

    always #2 mclk = ~mclk;

    iop_port #(.TWI_PINS(TWI)) u_dut (.mclk(mclk), .srst(srst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack),
        .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .pullUpEn(pullUp), .pullDownEn(pullDown), .analogEn(analog),
        .periphOut(periphOut), .periphIn(periphIn), .cnIrq(cnIrq));

    iop_pin_model u_pins (.mclk(mclk), .padOut(padOut), .padOe(padOe),
        .pullUpEn(pullUp), .pullDownEn(pullDown), .extVal(extVal),
        .extEn(extEn), .padIn(padIn));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Classic single cycle; the next call leaves one idle cycle first.
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        @(posedge mclk);
        while (ack !== 1'b1 && n < 50) begin
            n++;
            @(posedge mclk);
        end
        rdat = datO;
        chk(ack, 1, "ack");
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask : wb

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    function automatic logic [15:0] ra(input logic [3:0] i,
                                       input logic [1:0] op = 2'h0);
        return {iop_pkg::PORT_PAGE, i, op, 2'b00};
    endfunction : ra

    function automatic logic [15:0] eOut(input logic [15:0] src, od);
        return src & ~(od | TWI);
    endfunction : eOut

    function automatic logic [15:0] eOe(input logic [15:0] dir, src, od);
        return ~dir & ~((od | TWI) & src);
    endfunction : eOe

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] l, o, v, e, oe, pins;
        logic [15:0] osel [5];
        logic [2:0]  k;
        osel = '{16'hFC04, 16'hFC98, 16'hFC9C, 16'hFCA0, 16'hFCA4};
        repeat (12) @(posedge mclk);
        srst <= 0;
        extVal <= $random(seed);
        wb(0, ra(iop_pkg::IDX_DIR), 0);
        chk(rdat, 32'h0000_FFFF, "dir reset");
        wb(0, ra(iop_pkg::IDX_ANSEL), 0);
        chk(rdat, 32'h0000_FFFF, "analog reset");
        chk(padOe, 0, "oe reset");
        chk(analog, 16'hFFFF, "analog out reset");
        foreach (osel[i]) begin
            wb(0, osel[i], 0);
            chk(rdat, 0, "out select reset");
        end
        $display("reset test done");
        // Digital use needs analog select cleared first.
        wb(1, ra(iop_pkg::IDX_ANSEL), 0);
        l = $random(seed);
        wb(1, ra(iop_pkg::IDX_PORT), l);
        wb(0, ra(iop_pkg::IDX_LAT), 0);
        chk(rdat, {16'h0000, l}, "latch");
        for (int op = 1; op < 4; op++) begin
            v = $random(seed);
            wb(1, ra(iop_pkg::IDX_LAT, op[1:0]), v);
            l = op == 1 ? l & ~v : op == 2 ? l | v : l ^ v;
            wb(0, ra(iop_pkg::IDX_LAT, op[1:0]), 0);
            chk(rdat, 0, "alias read");
            wb(0, ra(iop_pkg::IDX_LAT), 0);
            chk(rdat, {16'h0000, l}, "alias op");
        end
        $display("latch test done");
        wb(1, ra(iop_pkg::IDX_DIR), 0);
        wb(1, 16'hFC04, 1);
        wb(1, 16'hFCA4, 2);
        for (int i = 0; i < 4; i++) begin
            o = $random(seed);
            v = $random(seed);
            periphOut <= v;
            wb(1, ra(iop_pkg::IDX_ODC), o);
            e = l;
            e[1] = v[1];
            tick(3);
            oe = eOe(0, e, o);
            chk(padOut, eOut(e, o), "pad out");
            chk(padOe, oe, "pad oe");
            pins = (oe & eOut(e, o)) | (~oe & extVal);
            // The three ticks after the open-drain write cover the settle time.
            wb(0, ra(iop_pkg::IDX_PORT), 0);
            chk(rdat, {16'h0000, pins}, "port read");
            wb(1, ra(iop_pkg::IDX_ANSEL, iop_pkg::OP_SET), 16'hFFFF);
            tick(3);
            chk(padOe, oe, "oe with analog");
            wb(0, ra(iop_pkg::IDX_PORT), 0);
            chk(rdat, 0, "analog port read");
            wb(1, ra(iop_pkg::IDX_ANSEL, iop_pkg::OP_CLR), 16'hFFFF);
        end
        wb(1, 16'hFC04, 0);
        tick(3);
        chk(padOut, eOut(l, o), "no connect");
        $display("drive test done");
        wb(1, ra(iop_pkg::IDX_DIR), 16'hFFFF);
        for (int c = 0; c < 16; c++) begin
            k = $random(seed);
            wb(1, 16'hFA00 + 16'(4 * k), c);
            tick(5);
            chk(periphIn[k], (c == 10 || c >= 14) ? 0 : extVal[c],
                "input select");
        end
        extVal[10] <= 1'b1;
        wb(1, 16'hFA00, 32'h0000_000A);
        tick(5);
        chk(periphIn[0], 0, "reserved code");
        $display("input select test done");
        wb(1, ra(iop_pkg::IDX_CNCON), 32'h0000_8000);
        wb(1, ra(iop_pkg::IDX_CNEN), 32'h0000_0010);
        wb(0, ra(iop_pkg::IDX_PORT), 0);
        tick(2);
        extVal[5] <= ~extVal[5];
        tick(6);
        chk(cnIrq, 0, "disabled pin");
        wb(0, ra(iop_pkg::IDX_CNST), 0);
        chk(rdat[5], 1, "status set");
        extVal[4] <= ~extVal[4];
        tick(6);
        chk(cnIrq, 1, "request");
        wb(0, ra(iop_pkg::IDX_PORT), 0);
        tick(3);
        chk(cnIrq, 0, "request cleared");
        wb(0, ra(iop_pkg::IDX_CNST), 0);
        chk(rdat, 0, "status cleared");
        $display("change test done");
        v = $random(seed);
        wb(1, ra(iop_pkg::IDX_PU), v);
        wb(1, ra(iop_pkg::IDX_PD, iop_pkg::OP_SET), ~v);
        tick(2);
        chk(pullUp, v, "pull up");
        e = ~v;
        chk(pullDown, e, "pull down");
        extEn <= 16'h0000;
        tick(4);
        wb(0, ra(iop_pkg::IDX_PORT), 0);
        chk(rdat, {16'h0000, v}, "pulled pins");
        wb(0, 16'h0F00, 0);
        chk(rdat, 0, "unmapped");
        $display("pull test done");
        stop_test();
    end
endmodule : testbench
